//--- common/bmc_pkg.sv
package bmc_pkg;

    localparam int unsigned BMC_AW = 8;
    localparam int unsigned BMC_DW = 32;

    // Register offsets
    localparam logic [7:0] BMC_OFF_CTRL = 8'h00;
    localparam logic [7:0] BMC_OFF_SRC = 8'h04;
    localparam logic [7:0] BMC_OFF_CFG_TO = 8'h08;
    localparam logic [7:0] BMC_OFF_ACT_TO = 8'h0c;
    localparam logic [7:0] BMC_OFF_STATUS = 8'h10;
    localparam logic [7:0] BMC_OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] BMC_OFF_IRQ_MASK = 8'h18;

    // Control field positions
    localparam int unsigned BMC_CTRL_STARTUP_BEACON = 0;
    localparam int unsigned BMC_CTRL_TO_BEACON = 1;
    localparam int unsigned BMC_CTRL_ACCEL_EN = 2;

    // Event source field positions
    localparam int unsigned BMC_SRC_ACT_LSB = 0;
    localparam int unsigned BMC_SRC_ONOFF = 4;
    localparam int unsigned BMC_SRC_CFG = 5;

    // Interrupt bit positions
    localparam int unsigned BMC_IRQ_MODE = 0;
    localparam int unsigned BMC_IRQ_FAIL = 1;
    localparam int unsigned BMC_IRQ_LOCK = 2;
    localparam int unsigned BMC_IRQ_ACT = 3;
    localparam int unsigned BMC_IRQ_CFG_TO = 4;
    localparam int unsigned BMC_IRQ_W = 5;

    // Values after reset
    localparam logic BMC_RST_STARTUP_BEACON = 1'b1;
    localparam logic BMC_RST_TO_BEACON = 1'b0;
    localparam logic BMC_RST_ACCEL_EN = 1'b1;
    localparam logic [2:0] BMC_RST_ACT_SRC = 3'h0;
    localparam logic BMC_RST_ONOFF_SRC = 1'b0;
    localparam logic BMC_RST_CFG_SRC = 1'b1;
    localparam logic [15:0] BMC_RST_TIMEOUT = 16'h0258;
    localparam logic [4:0] BMC_RST_IRQ_MASK = 5'h00;

    // Activity event sources
    typedef enum logic [2:0] {
        BMC_ACT_DISABLED = 3'h0,
        BMC_ACT_MOVE = 3'h1,
        BMC_ACT_TAP = 3'h2,
        BMC_ACT_DTAP = 3'h3,
        BMC_ACT_FREEFALL = 3'h4,
        BMC_ACT_FLIP = 3'h5
    } bmc_act_src_e;

    // Operating modes, one-hot
    typedef enum logic [5:0] {
        BMC_ST_SELFTEST = 6'h01,
        BMC_ST_WAREHOUSE = 6'h02,
        BMC_ST_BEACON = 6'h04,
        BMC_ST_CONFIG = 6'h08,
        BMC_ST_CONNECTED = 6'h10,
        BMC_ST_REBOOT = 6'h20
    } bmc_state_e;

    // Timebase: one tick each 0.1 s
    localparam int unsigned BMC_CLK_PERIOD_PS = 4000;
    localparam longint unsigned BMC_TICK_PERIOD_PS = 64'd100_000_000_000;
    localparam int unsigned BMC_TICK_CYCLES = int'(BMC_TICK_PERIOD_PS / BMC_CLK_PERIOD_PS);
    localparam logic [15:0] BMC_REBOOT_TENTHS = 16'h0064;

endpackage

//--- common/bmc_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bmc_tmr_if;
    logic start;
    logic tick;
    logic [15:0] load;
    logic expired;
    logic running;

    modport ctrl (output start, output tick, output load, input expired, input running);
    modport tmr (input start, input tick, input load, output expired, output running);
endinterface
`default_nettype wire

//--- src/bmc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_timer (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    bmc_tmr_if.tmr t
);
    logic [15:0] count;

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            count <= 16'h0000;
            t.running <= 1'b0;
            t.expired <= 1'b0;
        end
        else if (ce_in)
        begin
            t.expired <= 1'b0;
            if (t.start)
            begin
                // Zero would never expire, so it counts as one step
                count <= (t.load == 16'h0000) ? 16'h0001 : t.load;
                t.running <= 1'b1;
            end
            else if (t.running && t.tick)
            begin
                if (count == 16'h0001)
                begin
                    t.running <= 1'b0;
                    t.expired <= 1'b1;
                end
                else
                begin
                    count <= count - 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- src/bmc_mode_ctrl.sv
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bmc_mode_ctrl #(
    parameter int unsigned TICK_CYCLES = bmc_pkg::BMC_TICK_CYCLES,
    parameter logic [15:0] REBOOT_TENTHS = bmc_pkg::BMC_REBOOT_TENTHS
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic [bmc_pkg::BMC_AW-1:0] addr_in,
    input wire logic [bmc_pkg::BMC_DW-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [bmc_pkg::BMC_DW-1:0] rdata_out,
    input wire logic sensor_ok_in,
    input wire logic hf_xtal_ok_in,
    input wire logic lf_xtal_ok_in,
    input wire logic cfg_valid_in,
    input wire logic move_evt_in,
    input wire logic tap_evt_in,
    input wire logic dtap_evt_in,
    input wire logic freefall_evt_in,
    input wire logic flip_evt_in,
    input wire logic lock_evt_in,
    input wire logic conn_in,
    input wire logic reset_req_in,
    output var bmc_pkg::bmc_state_e mode_out,
    output logic sensor_en_out,
    output logic active_out,
    output logic device_reset_out,
    output logic irq_out
);
    import bmc_pkg::*;
    localparam int unsigned PW = $clog2(TICK_CYCLES + 1);
    bmc_state_e state;
    logic startup_beacon;
    logic to_beacon;
    logic accel_en;
    bmc_act_src_e act_src;
    logic onoff_src;
    logic cfg_src;
    logic [15:0] cfg_to;
    logic [15:0] act_to;
    logic [4:0] irq_mask;
    logic [4:0] irq_stat;
    logic [3:0] err_code;
    logic failed;
    logic locked;
    logic rst_requested;
    logic [PW-1:0] presc;
    logic tick;
    logic cfg_evt;
    logic onoff_evt;
    logic act_evt;
    logic enter_cfg;
    logic leave_conn;
    logic mode_chg;
    bmc_state_e startup_state;
    bmc_state_e next_state;
    logic [4:0] irq_evt;
    bmc_tmr_if cfg_t ();
    bmc_tmr_if act_t ();
    bmc_tmr_if rbt_t ();
    bmc_timer u_cfg_timer (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .t(cfg_t)
    );
    bmc_timer u_act_timer (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .t(act_t)
    );
    bmc_timer u_reboot_timer (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .t(rbt_t)
    );
    // 0.1 s timebase shared by all timers
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            presc <= '0;
        else if (ce_in)
            presc <= tick ? '0 : presc + PW'(1);
    end
    assign tick = (presc == PW'(TICK_CYCLES - 1));
    // Event decoding; a disabled sensor yields no events
    always_comb
    begin
        cfg_evt = accel_en && !failed && cfg_src && flip_evt_in;
        onoff_evt = accel_en && !failed && onoff_src && flip_evt_in;
        case (act_src)
            BMC_ACT_MOVE: act_evt = move_evt_in;
            BMC_ACT_TAP: act_evt = tap_evt_in;
            BMC_ACT_DTAP: act_evt = dtap_evt_in;
            BMC_ACT_FREEFALL: act_evt = freefall_evt_in;
            BMC_ACT_FLIP: act_evt = flip_evt_in;
            default: act_evt = 1'b0;
        endcase
        act_evt = act_evt && accel_en && !failed;
    end
    assign startup_state = startup_beacon ? BMC_ST_BEACON : BMC_ST_WAREHOUSE;
    // Mode sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            BMC_ST_SELFTEST:
            begin
                if (sensor_ok_in && hf_xtal_ok_in && lf_xtal_ok_in && cfg_valid_in)
                    next_state = startup_state;
                else
                    next_state = BMC_ST_CONFIG;
            end
            BMC_ST_WAREHOUSE:
            begin
                // Lock wins: it must also take effect when events coincide
                if (lock_evt_in)
                    next_state = BMC_ST_BEACON;
                else if (cfg_evt && !locked)
                    next_state = BMC_ST_CONFIG;
                else if (onoff_evt && !locked)
                    next_state = BMC_ST_BEACON;
            end
            BMC_ST_BEACON:
            begin
                if (cfg_evt && !locked)
                    next_state = BMC_ST_CONFIG;
                else if (onoff_evt && !locked)
                    next_state = BMC_ST_WAREHOUSE;
            end
            BMC_ST_CONFIG:
            begin
                if (conn_in)
                    next_state = BMC_ST_CONNECTED;
                else if (failed && rbt_t.expired)
                    next_state = BMC_ST_REBOOT;
                else if (cfg_t.expired && !failed)
                    next_state = to_beacon ? BMC_ST_BEACON : startup_state;
            end
            BMC_ST_CONNECTED:
            begin
                if (!conn_in)
                begin
                    if (rst_requested || reset_req_in)
                        next_state = BMC_ST_REBOOT;
                    else if (failed)
                        next_state = BMC_ST_CONFIG;
                    else
                        next_state = startup_state;
                end
                else if (failed && rbt_t.expired)
                    next_state = BMC_ST_REBOOT;
            end
            BMC_ST_REBOOT:
                next_state = BMC_ST_REBOOT;
            default:
                next_state = BMC_ST_SELFTEST;
        endcase
    end
    assign enter_cfg = (next_state == BMC_ST_CONFIG) && (state != BMC_ST_CONFIG);
    assign leave_conn = (state == BMC_ST_CONNECTED) && !conn_in;
    assign mode_chg = (next_state != state);

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            state <= BMC_ST_SELFTEST;
        else if (ce_in)
            state <= next_state;
    end

    // Failure record, held until the next reset
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            failed <= 1'b0;
            err_code <= 4'h0;
        end
        else if (ce_in && state == BMC_ST_SELFTEST)
        begin
            failed <= !(sensor_ok_in && hf_xtal_ok_in && lf_xtal_ok_in && cfg_valid_in);
            err_code <= {!cfg_valid_in, !lf_xtal_ok_in, !hf_xtal_ok_in, !sensor_ok_in};
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            locked <= 1'b0;
        else if (ce_in && lock_evt_in && state != BMC_ST_SELFTEST)
            locked <= 1'b1;
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            rst_requested <= 1'b0;
        else if (ce_in)
        begin
            if (state != BMC_ST_CONNECTED || leave_conn)
                rst_requested <= 1'b0;
            else if (reset_req_in)
                rst_requested <= 1'b1;
        end
    end

    // Timer control
    assign cfg_t.tick = tick;
    assign cfg_t.load = cfg_to;
    assign cfg_t.start = ce_in && enter_cfg;
    assign act_t.tick = tick;
    assign act_t.load = act_to;
    assign act_t.start = ce_in && act_evt && state == BMC_ST_BEACON;
    assign rbt_t.tick = tick;
    assign rbt_t.load = REBOOT_TENTHS;
    // Reboot delay runs once from the failed self-test, also across connections
    assign rbt_t.start = ce_in && state == BMC_ST_SELFTEST && next_state == BMC_ST_CONFIG;

    // Software-visible configuration
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            startup_beacon <= BMC_RST_STARTUP_BEACON;
            to_beacon <= BMC_RST_TO_BEACON;
            accel_en <= BMC_RST_ACCEL_EN;
            act_src <= bmc_act_src_e'(BMC_RST_ACT_SRC);
            onoff_src <= BMC_RST_ONOFF_SRC;
            cfg_src <= BMC_RST_CFG_SRC;
            cfg_to <= BMC_RST_TIMEOUT;
            act_to <= BMC_RST_TIMEOUT;
            irq_mask <= BMC_RST_IRQ_MASK;
        end
        else if (ce_in && wr_in)
        begin
            if (addr_in == BMC_OFF_CTRL)
            begin
                startup_beacon <= wdata_in[BMC_CTRL_STARTUP_BEACON];
                to_beacon <= wdata_in[BMC_CTRL_TO_BEACON];
                accel_en <= wdata_in[BMC_CTRL_ACCEL_EN];
            end
            else if (addr_in == BMC_OFF_SRC)
            begin
                // Unknown codes fall back to disabled
                if (wdata_in[BMC_SRC_ACT_LSB +: 3] <= BMC_ACT_FLIP)
                    act_src <= bmc_act_src_e'(wdata_in[BMC_SRC_ACT_LSB +: 3]);
                else
                    act_src <= BMC_ACT_DISABLED;
                onoff_src <= wdata_in[BMC_SRC_ONOFF];
                cfg_src <= wdata_in[BMC_SRC_CFG];
            end
            else if (addr_in == BMC_OFF_CFG_TO)
                cfg_to <= wdata_in[15:0];
            else if (addr_in == BMC_OFF_ACT_TO)
                act_to <= wdata_in[15:0];
            else if (addr_in == BMC_OFF_IRQ_MASK)
                irq_mask <= wdata_in[BMC_IRQ_W-1:0];
        end
    end

    // Sticky events; a new event beats the read that clears
    assign irq_evt = {cfg_t.expired, act_evt, lock_evt_in && !locked,
        state == BMC_ST_SELFTEST && next_state == BMC_ST_CONFIG, mode_chg};

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            irq_stat <= '0;
        else if (ce_in)
        begin
            if (rd_in && addr_in == BMC_OFF_IRQ_STAT)
                irq_stat <= irq_evt;
            else
                irq_stat <= irq_stat | irq_evt;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            rdata_out <= '0;
        else if (ce_in)
        begin
            if (!rd_in)
                rdata_out <= '0;
            else if (addr_in == BMC_OFF_CTRL)
                rdata_out <= {29'h0, accel_en, to_beacon, startup_beacon};
            else if (addr_in == BMC_OFF_SRC)
                rdata_out <= {26'h0, cfg_src, onoff_src, 1'b0, act_src};
            else if (addr_in == BMC_OFF_CFG_TO)
                rdata_out <= {16'h0, cfg_to};
            else if (addr_in == BMC_OFF_ACT_TO)
                rdata_out <= {16'h0, act_to};
            else if (addr_in == BMC_OFF_STATUS)
                rdata_out <= {20'h0, err_code, locked, failed, state};
            else if (addr_in == BMC_OFF_IRQ_STAT)
                rdata_out <= {27'h0, irq_stat};
            else if (addr_in == BMC_OFF_IRQ_MASK)
                rdata_out <= {27'h0, irq_mask};
            else
                rdata_out <= '0;
        end
    end

    assign mode_out = state;
    assign sensor_en_out = accel_en && !failed;
    assign active_out = act_t.running && state == BMC_ST_BEACON;
    assign device_reset_out = (state == BMC_ST_REBOOT);
    assign irq_out = |(irq_stat & irq_mask);
endmodule
`default_nettype wire

//--- verif/bmc_mode_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_mode_ctrl_asserts
    import bmc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 10,
    parameter logic [15:0] REBOOT_TENTHS = 16'h0003
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic sensor_ok_in,
    input wire logic hf_xtal_ok_in,
    input wire logic lf_xtal_ok_in,
    input wire logic cfg_valid_in,
    input wire logic flip_evt_in,
    input wire logic lock_evt_in,
    input wire logic conn_in,
    input wire logic [5:0] mode_out,
    input wire logic sensor_en_out,
    input wire logic active_out,
    input wire logic device_reset_out
);
    logic ok_all;
    assign ok_all = sensor_ok_in & hf_xtal_ok_in & lf_xtal_ok_in & cfg_valid_in;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    // Past values from inside reset are kept out of the self-test checks
    a_power_on_self_test_pass: assert property (!$past(reset_in) && $past(ce_in) &&
        $past(mode_out) == BMC_ST_SELFTEST && $past(ok_all)
        |-> mode_out inside {BMC_ST_WAREHOUSE, BMC_ST_BEACON}) else $error("no startup mode");
    a_power_on_self_test_fail: assert property (!$past(reset_in) && $past(ce_in) &&
        $past(mode_out) == BMC_ST_SELFTEST && !$past(ok_all)
        |-> mode_out == BMC_ST_CONFIG) else $error("no config after failure");
    a_fail_sensor: assert property (!$past(reset_in) &&
        $past(mode_out) == BMC_ST_SELFTEST && mode_out == BMC_ST_CONFIG && !$past(ok_all)
        |-> !sensor_en_out) else $error("sensor left on");
    a_reboot_out: assert property (device_reset_out == (mode_out == BMC_ST_REBOOT))
        else $error("reset output wrong");
    a_reboot_hold: assert property (mode_out == BMC_ST_REBOOT |=> mode_out == BMC_ST_REBOOT)
        else $error("reboot left");
    a_lock_exit: assert property (mode_out == BMC_ST_WAREHOUSE && ce_in && lock_evt_in &&
        !flip_evt_in |=> mode_out == BMC_ST_BEACON) else $error("lock ignored");
    a_conn_enter: assert property (mode_out == BMC_ST_CONFIG && ce_in && conn_in &&
        sensor_en_out |=> mode_out == BMC_ST_CONNECTED) else $error("connect ignored");
    a_disc_exit: assert property (mode_out == BMC_ST_CONNECTED && ce_in && !conn_in &&
        sensor_en_out |=> mode_out inside {BMC_ST_WAREHOUSE, BMC_ST_BEACON, BMC_ST_REBOOT})
        else $error("bad exit after connection");
    a_act_beacon: assert property (active_out |-> mode_out == BMC_ST_BEACON ||
        $past(mode_out) == BMC_ST_BEACON) else $error("active outside beacon");
endmodule
bind bmc_mode_ctrl bmc_mode_ctrl_asserts #(
    .TICK_CYCLES(TICK_CYCLES),
    .REBOOT_TENTHS(REBOOT_TENTHS)
) u_chk (
    .mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce_in), .sensor_ok_in(sensor_ok_in),
    .hf_xtal_ok_in(hf_xtal_ok_in), .lf_xtal_ok_in(lf_xtal_ok_in), .cfg_valid_in(cfg_valid_in),
    .flip_evt_in(flip_evt_in), .lock_evt_in(lock_evt_in), .conn_in(conn_in),
    .mode_out(mode_out), .sensor_en_out(sensor_en_out), .active_out(active_out),
    .device_reset_out(device_reset_out)
);
`default_nettype wire

//--- verif/bmc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_far_model (
    input wire logic mclk_in,
    output logic [3:0] ok_out,
    output logic [4:0] evt_out,
    output logic lock_out,
    output logic conn_out,
    output logic rreq_out
);
    initial
    begin
        ok_out = 4'hf;
        evt_out = 5'h00;
        lock_out = 1'b0;
        conn_out = 1'b0;
        rreq_out = 1'b0;
    end
    // Self-test results, set just before reset is raised
    task automatic set_ok(input logic [3:0] v);
        ok_out <= v;
    endtask
    task automatic pulse(input int i);
        @(posedge mclk_in);
        evt_out[i] <= 1'b1;
        @(posedge mclk_in);
        evt_out[i] <= 1'b0;
    endtask
    task automatic pulse_lock;
        @(posedge mclk_in);
        lock_out <= 1'b1;
        @(posedge mclk_in);
        lock_out <= 1'b0;
    endtask
    task automatic conn_up;
        @(posedge mclk_in);
        conn_out <= 1'b1;
    endtask
    // Slow central: holds the link a while before dropping it
    task automatic conn_down(input logic req, input int hold);
        if (req)
        begin
            @(posedge mclk_in);
            rreq_out <= 1'b1;
            @(posedge mclk_in);
            rreq_out <= 1'b0;
        end
        repeat (hold) @(posedge mclk_in);
        conn_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verif/beacon_mode_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
module beacon_mode_controller_test;
    import bmc_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic ce = 1'b1;
    logic [31:0] rdata, e, m, v;
    logic [3:0] ok;
    logic [4:0] evt;
    logic lock, conn, rreq, sensor_en, active, dev_rst, irq;
    bmc_state_e mode;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int miscompares = 0;
    int checks = 0;
    integer seed = 32'hc7293cb8;
    int k;
    initial forever #2 mclk_in = ~mclk_in;
    // Short prescaler keeps the run small; timeouts are counted in ticks of 10 cycles
    bmc_mode_ctrl #(.TICK_CYCLES(10), .REBOOT_TENTHS(16'h0014)) u_dut (
        .mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sensor_ok_in(ok[0]),
        .hf_xtal_ok_in(ok[1]), .lf_xtal_ok_in(ok[2]), .cfg_valid_in(ok[3]),
        .move_evt_in(evt[0]), .tap_evt_in(evt[1]), .dtap_evt_in(evt[2]),
        .freefall_evt_in(evt[3]), .flip_evt_in(evt[4]), .lock_evt_in(lock), .conn_in(conn),
        .reset_req_in(rreq), .mode_out(mode), .sensor_en_out(sensor_en),
        .active_out(active), .device_reset_out(dev_rst), .irq_out(irq));
    bmc_far_model u_far (.mclk_in(mclk_in), .ok_out(ok), .evt_out(evt), .lock_out(lock),
        .conn_out(conn), .rreq_out(rreq));
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] x, input logic [31:0] mk);
        @(posedge mclk_in);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(x);
        msk_q.push_back(mk);
        @(posedge mclk_in);
        rd <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge mclk_in)
    begin
        rd_d <= rd;
        if (rd_d)
        begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk("rdata", e, rdata & m);
        end
    end
    task automatic wait_mode(input bmc_state_e s);
        int i;
        for (i = 0; i < 400 && mode !== s; i++)
            @(negedge mclk_in);
        chk("mode", {26'h0, s}, {26'h0, mode});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic do_reset(input logic [3:0] r);
        u_far.set_ok(r);
        @(posedge mclk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        reset_in <= 1'b0;
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #100000;
        miscompares++;
        complete_run();
    end
    initial
    begin
        do_reset(4'hf);
        wait_mode(BMC_ST_BEACON);
        rd_reg(BMC_OFF_CTRL, 32'h5, '1);
        rd_reg(BMC_OFF_SRC, 32'h20, '1);
        rd_reg(BMC_OFF_CFG_TO, 32'h258, '1);
        rd_reg(BMC_OFF_ACT_TO, 32'h258, '1);
        rd_reg(BMC_OFF_IRQ_MASK, 32'h0, '1);
        rd_reg(8'h1c, 32'h0, '1);
        chk("sensor_en", 32'h1, 32'(sensor_en));
        for (k = 0; k < 8; k++)
        begin
            wr_reg(BMC_OFF_SRC, 32'(k));
            rd_reg(BMC_OFF_SRC, (k > 5) ? 32'h0 : 32'(k), 32'h7);
        end
        v = $random(seed);
        wr_reg(BMC_OFF_CFG_TO, v);
        rd_reg(BMC_OFF_CFG_TO, {16'h0, v[15:0]}, '1);
        // Tap as activity, flip as on/off
        wr_reg(BMC_OFF_ACT_TO, 32'h3);
        wr_reg(BMC_OFF_SRC, 32'h12);
        rd_reg(BMC_OFF_IRQ_STAT, 32'h0, 32'h0);
        wr_reg(BMC_OFF_IRQ_MASK, 32'h1f);
        u_far.pulse(1);
        cyc(10);
        chk("active", 32'h1, 32'(active));
        chk("irq", 32'h1, 32'(irq));
        wr_reg(BMC_OFF_IRQ_MASK, 32'h0);
        cyc(1);
        chk("irq", 32'h0, 32'(irq));
        cyc(40);
        chk("active", 32'h0, 32'(active));
        wr_reg(BMC_OFF_IRQ_MASK, 32'h1f);
        rd_reg(BMC_OFF_IRQ_STAT, 32'h8, 32'h8);
        cyc(2);
        chk("irq", 32'h0, 32'(irq));
        // Move, double tap and freefall react to their own event and not to tap, which stays unselected here
        for (k = 0; k < 3; k++)
        begin
            wr_reg(BMC_OFF_SRC, (k == 0) ? 32'h1 : 32'(k + 2));
            rd_reg(BMC_OFF_IRQ_STAT, 32'h0, 32'h0);
            u_far.pulse(1);
            cyc(2);
            chk("active", 32'h0, 32'(active));
            rd_reg(BMC_OFF_IRQ_STAT, 32'h0, 32'h8);
            u_far.pulse((k == 0) ? 0 : k + 1);
            cyc(2);
            chk("active", 32'h1, 32'(active));
            rd_reg(BMC_OFF_IRQ_STAT, 32'h8, 32'h8);
            cyc(30);
        end
        wr_reg(BMC_OFF_SRC, 32'h12);
        u_far.pulse(4);
        wait_mode(BMC_ST_WAREHOUSE);
        u_far.pulse(4);
        wait_mode(BMC_ST_BEACON);
        wr_reg(BMC_OFF_SRC, 32'h20);
        wr_reg(BMC_OFF_CTRL, 32'h4);
        wr_reg(BMC_OFF_CFG_TO, 32'h2);
        u_far.pulse(4);
        wait_mode(BMC_ST_CONFIG);
        wait_mode(BMC_ST_WAREHOUSE);
        u_far.pulse(4);
        wait_mode(BMC_ST_CONFIG);
        wr_reg(BMC_OFF_CTRL, 32'h6);
        wait_mode(BMC_ST_BEACON);
        wr_reg(BMC_OFF_CFG_TO, 32'h64);
        u_far.pulse(4);
        wait_mode(BMC_ST_CONFIG);
        u_far.conn_up();
        wait_mode(BMC_ST_CONNECTED);
        u_far.conn_down(1'b0, 4);
        wait_mode(BMC_ST_WAREHOUSE);
        u_far.pulse_lock();
        wait_mode(BMC_ST_BEACON);
        u_far.pulse(4);
        cyc(5);
        rd_reg(BMC_OFF_STATUS, 32'h84, 32'hff);
        // Sensor check fails on the second reset
        do_reset(4'he);
        wait_mode(BMC_ST_CONFIG);
        chk("sensor_en", 32'h0, 32'(sensor_en));
        rd_reg(BMC_OFF_STATUS, 32'h148, 32'hfff);
        // Re-entry after the link drops reloads the short configuration timer
        wr_reg(BMC_OFF_CFG_TO, 32'h1);
        u_far.conn_up();
        wait_mode(BMC_ST_CONNECTED);
        rd_reg(BMC_OFF_STATUS, 32'h100, 32'hf00);
        u_far.conn_down(1'b0, 1);
        wait_mode(BMC_ST_CONFIG);
        cyc(30);
        wait_mode(BMC_ST_CONFIG);
        rd_reg(BMC_OFF_IRQ_STAT, 32'h10, 32'h10);
        wait_mode(BMC_ST_REBOOT);
        chk("device_reset", 32'h1, 32'(dev_rst));
        // Each of the other three checks failing on its own
        for (k = 1; k < 4; k++)
        begin
            do_reset(4'hf ^ 4'(1 << k));
            wait_mode(BMC_ST_CONFIG);
            rd_reg(BMC_OFF_STATUS, 32'h48 | (32'h100 << k), 32'hfff);
        end
        do_reset(4'hf);
        wait_mode(BMC_ST_BEACON);
        // Nothing moves while the clock enable is low
        @(posedge mclk_in);
        ce <= 1'b0;
        u_far.pulse(4);
        cyc(3);
        chk("mode", {26'h0, BMC_ST_BEACON}, {26'h0, mode});
        @(posedge mclk_in);
        ce <= 1'b1;
        u_far.pulse(4);
        wait_mode(BMC_ST_CONFIG);
        u_far.conn_up();
        wait_mode(BMC_ST_CONNECTED);
        u_far.conn_down(1'b1, 2);
        wait_mode(BMC_ST_REBOOT);
        cyc(3);
        complete_run();
    end
endmodule
`default_nettype wire
